// ### core/pios_pkg.sv
// constants and types of the parallel io pattern select block
package pios_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] OFS_PATTERN = 8'h00;
   localparam logic [7:0] OFS_ZONE_LO = 8'h04;
   localparam logic [7:0] OFS_ZONE_HI = 8'h08;
   localparam logic [7:0] OFS_TBL_LO = 8'h0C;
   localparam logic [7:0] OFS_TBL_HI = 8'h10;
   localparam logic [7:0] OFS_POS = 8'h14;
   localparam logic [7:0] OFS_CTRL = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_PARAM_NO = 8'h20;
   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam logic [2:0] PATTERN_MAX = 3'h5;
   localparam logic [2:0] PATTERN_RST = 3'h0;
   localparam logic [7:0] PATTERN_PARAM_NO = 8'h19;
   localparam logic [9:0] POINTS_P64 = 10'h040;
   localparam logic [9:0] POINTS_P256 = 10'h100;
   localparam logic [9:0] POINTS_P512 = 10'h200;
   localparam logic [9:0] POINTS_SOL7 = 10'h007;
   localparam logic [9:0] POINTS_SOL3 = 10'h003;
   localparam int CTRL_HOMED_BIT = 0;
   localparam int CTRL_MOVE_CMD_BIT = 1;
   localparam int CTRL_PUSH_BIT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // pattern codes
   // ----------------------------------------
   typedef enum logic [2:0] {
      PAT_STANDARD = 3'h0,
      PAT_TEACH = 3'h1,
      PAT_P256 = 3'h2,
      PAT_P512 = 3'h3,
      PAT_SOL7 = 3'h4,
      PAT_SOL3 = 3'h5
   } pios_pattern_e;
endpackage

// ### core/pios_zone_cmp.sv
// window comparator with a validity gate, one per zone output
`timescale 1ns/10ps
`default_nettype none
module pios_zone_cmp #(
   parameter int WIDTH = 32
) (
   input wire logic [WIDTH-1:0] i_pos,
   input wire logic [WIDTH-1:0] i_lo,
   input wire logic [WIDTH-1:0] i_hi,
   input wire logic i_enable,
   output logic o_inside
);
   assign o_inside = i_enable && ($signed(i_pos) >= $signed(i_lo))
                     && ($signed(i_pos) <= $signed(i_hi));
endmodule
`default_nettype wire

// ### core/pios_top.sv
// parallel io pattern select: pattern decode, zone outputs, axi4-lite registers
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module pios_top #(
   parameter int POS_WIDTH = 32
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   // axi4-lite slave
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // motion side
   input wire logic i_servo_ready,
   input wire logic [6:0] i_at_point,
   // parallel io gated functions
   input wire logic i_brake_release,
   input wire logic i_home,
   input wire logic i_jog_plus,
   input wire logic i_jog_minus,
   input wire logic i_pos_write,
   output logic o_brake_release,
   output logic o_home,
   output logic o_jog_plus,
   output logic o_jog_minus,
   output logic o_pos_write,
   output logic o_parameter_zone_output,
   output logic o_table_zone_output,
   output logic o_ready,
   output logic [9:0] o_point_count,
   output logic o_direct_select,
   output logic o_complete_as_detect,
   output logic o_push_enable,
   output logic [6:0] o_point_detect
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] pattern;
      logic [POS_WIDTH-1:0] zone_lo;
      logic [POS_WIDTH-1:0] zone_hi;
      logic [POS_WIDTH-1:0] tbl_lo;
      logic [POS_WIDTH-1:0] tbl_hi;
      logic [POS_WIDTH-1:0] pos;
      logic homed;
      logic moved;
      logic push_req;
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic brake;
      logic home;
      logic jog_p;
      logic jog_m;
      logic pwrite;
      logic table_zone_output;
      logic tzone;
      logic ready;
      logic [9:0] points;
      logic direct;
      logic detect;
      logic push;
      logic [6:0] pdet;
   } pios_state_s;

   pios_state_s state_q;
   pios_state_s state_d;
   logic table_zone_output_in;
   logic tzone_in;

   // ----------------------------------------
   // zone comparators
   // ----------------------------------------
   pios_zone_cmp #(
      .WIDTH(POS_WIDTH)
   ) u_param_zone (
      .i_pos(state_q.pos),
      .i_lo(state_q.zone_lo),
      .i_hi(state_q.zone_hi),
      .i_enable(state_q.homed),
      .o_inside(table_zone_output_in)
   );

   pios_zone_cmp #(
      .WIDTH(POS_WIDTH)
   ) u_table_zone (
      .i_pos(state_q.pos),
      .i_lo(state_q.tbl_lo),
      .i_hi(state_q.tbl_hi),
      .i_enable(state_q.moved),
      .o_inside(tzone_in)
   );

   // ----------------------------------------
   // write merge with byte enables
   // ----------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // pattern feature table
   // ----------------------------------------
   // which pin functions the stored pattern keeps alive
   logic has_brake;
   logic has_home;
   logic has_teach_io;
   logic has_ready;
   logic has_table_zone_output;
   logic has_tzone;
   logic has_direct;
   logic has_detect;
   logic has_push;

   assign has_brake = state_q.pattern != pios_pkg::PAT_TEACH;
   assign has_home = state_q.pattern != pios_pkg::PAT_SOL3;
   assign has_teach_io = state_q.pattern == pios_pkg::PAT_TEACH;
   assign has_ready = (state_q.pattern == pios_pkg::PAT_STANDARD)
                      || (state_q.pattern == pios_pkg::PAT_TEACH);
   assign has_table_zone_output = (state_q.pattern == pios_pkg::PAT_STANDARD)
                      || (state_q.pattern == pios_pkg::PAT_SOL7)
                      || (state_q.pattern == pios_pkg::PAT_SOL3);
   assign has_tzone = state_q.pattern != pios_pkg::PAT_P512;
   assign has_direct = (state_q.pattern == pios_pkg::PAT_SOL7)
                       || (state_q.pattern == pios_pkg::PAT_SOL3);
   assign has_detect = state_q.pattern == pios_pkg::PAT_SOL3;
   assign has_push = state_q.pattern != pios_pkg::PAT_SOL3;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [31:0] wv;
      logic [7:0] wa;
      logic [2:0] pat;
      wv = 32'h0000_0000;
      wa = 8'h00;
      pat = 3'h0;
      state_d = state_q;

      // write channel capture, either order
      if (state_q.awready && i_awvalid) begin
         state_d.aw_got = 1'b1;
         state_d.aw_addr = i_awaddr;
         state_d.awready = 1'b0;
      end
      if (state_q.wready && i_wvalid) begin
         state_d.w_got = 1'b1;
         state_d.w_data = i_wdata;
         state_d.w_strb = i_wstrb;
         state_d.wready = 1'b0;
      end
      if (state_q.bvalid && i_bready) begin
         state_d.bvalid = 1'b0;
         state_d.awready = 1'b1;
         state_d.wready = 1'b1;
      end

      if (state_q.aw_got && state_q.w_got && !state_q.bvalid) begin
         wa = state_q.aw_addr;
         state_d.aw_got = 1'b0;
         state_d.w_got = 1'b0;
         state_d.bvalid = 1'b1;
         state_d.bresp = pios_pkg::RESP_OKAY;
         unique case (wa)
            pios_pkg::OFS_PATTERN: begin
               wv = merge({29'h0000_0000, state_q.pattern}, state_q.w_data, state_q.w_strb);
               if (wv <= {29'h0000_0000, pios_pkg::PATTERN_MAX}) begin
                  state_d.pattern = wv[2:0];
               end else begin
                  state_d.bresp = pios_pkg::RESP_SLVERR;
               end
            end
            pios_pkg::OFS_ZONE_LO: state_d.zone_lo = merge(state_q.zone_lo, state_q.w_data,
                                                          state_q.w_strb);
            pios_pkg::OFS_ZONE_HI: state_d.zone_hi = merge(state_q.zone_hi, state_q.w_data,
                                                          state_q.w_strb);
            pios_pkg::OFS_TBL_LO: state_d.tbl_lo = merge(state_q.tbl_lo, state_q.w_data,
                                                        state_q.w_strb);
            pios_pkg::OFS_TBL_HI: state_d.tbl_hi = merge(state_q.tbl_hi, state_q.w_data,
                                                        state_q.w_strb);
            pios_pkg::OFS_POS: state_d.pos = merge(state_q.pos, state_q.w_data, state_q.w_strb);
            pios_pkg::OFS_CTRL: begin
               wv = merge({29'h0000_0000, state_q.push_req, state_q.moved, state_q.homed},
                          state_q.w_data, state_q.w_strb);
               state_d.homed = wv[pios_pkg::CTRL_HOMED_BIT];
               state_d.moved = wv[pios_pkg::CTRL_MOVE_CMD_BIT];
               state_d.push_req = wv[pios_pkg::CTRL_PUSH_BIT];
            end
            default: state_d.bresp = pios_pkg::RESP_SLVERR;
         endcase
      end

      // read channel
      if (state_q.rvalid && i_rready) begin
         state_d.rvalid = 1'b0;
         state_d.arready = 1'b1;
      end
      if (state_q.arready && i_arvalid) begin
         state_d.arready = 1'b0;
         state_d.rvalid = 1'b1;
         state_d.rresp = pios_pkg::RESP_OKAY;
         unique case (i_araddr)
            pios_pkg::OFS_PATTERN: state_d.rdata = {29'h0000_0000, state_q.pattern};
            pios_pkg::OFS_ZONE_LO: state_d.rdata = state_q.zone_lo;
            pios_pkg::OFS_ZONE_HI: state_d.rdata = state_q.zone_hi;
            pios_pkg::OFS_TBL_LO: state_d.rdata = state_q.tbl_lo;
            pios_pkg::OFS_TBL_HI: state_d.rdata = state_q.tbl_hi;
            pios_pkg::OFS_POS: state_d.rdata = state_q.pos;
            pios_pkg::OFS_CTRL: state_d.rdata = {29'h0000_0000, state_q.push_req,
                                                 state_q.moved, state_q.homed};
            pios_pkg::OFS_STATUS: state_d.rdata = {20'h0_0000, state_q.points,
                                                   state_q.tzone, state_q.table_zone_output};
            pios_pkg::OFS_PARAM_NO: state_d.rdata = {24'h00_0000, pios_pkg::PATTERN_PARAM_NO};
            default: begin
               state_d.rdata = 32'h0000_0000;
               state_d.rresp = pios_pkg::RESP_SLVERR;
            end
         endcase
      end

      // ----------------------------------------
      // pattern decode
      // ----------------------------------------
      pat = state_q.pattern;
      state_d.brake = has_brake && i_brake_release;
      state_d.home = has_home && i_home;
      state_d.jog_p = has_teach_io && i_jog_plus;
      state_d.jog_m = has_teach_io && i_jog_minus;
      state_d.pwrite = has_teach_io && i_pos_write;
      state_d.ready = has_ready && i_servo_ready;
      state_d.table_zone_output = has_table_zone_output && table_zone_output_in;
      state_d.tzone = has_tzone && tzone_in;
      state_d.direct = has_direct;
      state_d.detect = has_detect;
      state_d.push = has_push && state_q.push_req;
      state_d.pdet = 7'h00;
      unique case (pat)
         pios_pkg::PAT_STANDARD: state_d.points = pios_pkg::POINTS_P64;
         pios_pkg::PAT_TEACH: state_d.points = pios_pkg::POINTS_P64;
         pios_pkg::PAT_P256: state_d.points = pios_pkg::POINTS_P256;
         pios_pkg::PAT_P512: state_d.points = pios_pkg::POINTS_P512;
         pios_pkg::PAT_SOL7: begin
            state_d.points = pios_pkg::POINTS_SOL7;
         end
         pios_pkg::PAT_SOL3: begin
            state_d.points = pios_pkg::POINTS_SOL3;
            state_d.pdet = {4'h0, i_at_point[2:0]};
         end
         // codes 6 and 7 are refused at the register, kept safe anyway
         default: state_d.points = pios_pkg::POINTS_P64;
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         state_q <= '0;
         state_q.pattern <= pios_pkg::PATTERN_RST;
         state_q.awready <= 1'b1;
         state_q.wready <= 1'b1;
         state_q.arready <= 1'b1;
         state_q.points <= pios_pkg::POINTS_P64;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_awready = state_q.awready;
   assign o_wready = state_q.wready;
   assign o_bresp = state_q.bresp;
   assign o_bvalid = state_q.bvalid;
   assign o_arready = state_q.arready;
   assign o_rdata = state_q.rdata;
   assign o_rresp = state_q.rresp;
   assign o_rvalid = state_q.rvalid;
   assign o_brake_release = state_q.brake;
   assign o_home = state_q.home;
   assign o_jog_plus = state_q.jog_p;
   assign o_jog_minus = state_q.jog_m;
   assign o_pos_write = state_q.pwrite;
   assign o_parameter_zone_output = state_q.table_zone_output;
   assign o_table_zone_output = state_q.tzone;
   assign o_ready = state_q.ready;
   assign o_point_count = state_q.points;
   assign o_direct_select = state_q.direct;
   assign o_complete_as_detect = state_q.detect;
   assign o_push_enable = state_q.push;
   assign o_point_detect = state_q.pdet;
endmodule
`default_nettype wire

// ### sim/pios_chk.sv
// pin assertions for the parallel io pattern select block
`timescale 1ns/10ps
`default_nettype none
module pios_chk (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic i_home,
   input wire logic o_home,
   input wire logic o_jog_plus,
   input wire logic o_jog_minus,
   input wire logic o_pos_write,
   input wire logic i_servo_ready,
   input wire logic o_ready,
   input wire logic [9:0] o_point_count,
   input wire logic o_table_zone_output,
   input wire logic o_parameter_zone_output,
   input wire logic o_complete_as_detect,
   input wire logic o_push_enable,
   input wire logic o_direct_select,
   input wire logic [6:0] o_point_detect,
   input wire logic [6:0] i_at_point
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   home_gate_a: assert property (
      o_home && $stable(o_point_count) |-> $past(i_home) && o_point_count != 10'h003)
      else $error("home line passed in three point mode");
   jog_gate_a: assert property (
      $stable(o_point_count) && (o_jog_plus || o_jog_minus || o_pos_write)
      |-> o_point_count == 10'h040) else $error("jog or write outside teaching");
   ready_gate_a: assert property (
      o_ready && $stable(o_point_count) |-> o_point_count == 10'h040 && $past(i_servo_ready))
      else $error("ready outside patterns 0 and 1");
   tzone_gate_a: assert property (
      o_table_zone_output && $stable(o_point_count) |-> o_point_count != 10'h200)
      else $error("table zone in 512 point mode");
   table_zone_output_gate_a: assert property (
      o_parameter_zone_output && $stable(o_point_count)
      |-> o_point_count inside {10'h040, 10'h007, 10'h003})
      else $error("parameter zone in wrong pattern");
   push_off_a: assert property (o_complete_as_detect |-> !o_push_enable)
      else $error("push in three point mode");
   mode_map_a: assert property ($changed(o_point_count) |->
      o_direct_select == (o_point_count < 10'h008)
      && o_complete_as_detect == (o_point_count == 10'h003)) else $error("mode flags off");
   detect_map_a: assert property ($stable(o_point_count) |->
      o_point_detect == (o_complete_as_detect ? ($past(i_at_point) & 7'h07) : 7'h00))
      else $error("point detect wrong");
   cover property (o_complete_as_detect && o_point_detect != 7'h00);
   cover property (o_parameter_zone_output);
   cover property (o_table_zone_output && o_ready);
endmodule
bind pios_top pios_chk chk_i (.i_clock, .i_sys_rst, .i_arvalid, .o_arready, .o_rvalid,
   .i_home, .o_home, .o_jog_plus, .o_jog_minus, .o_pos_write, .i_servo_ready, .o_ready,
   .o_point_count, .o_table_zone_output, .o_parameter_zone_output, .o_complete_as_detect,
   .o_push_enable, .o_direct_select, .o_point_detect, .i_at_point);
`default_nettype wire

// ### sim/pios_plc.sv
// plc model driving the parallel io lines
`timescale 1ns/10ps
`default_nettype none
module pios_plc (
   input wire logic i_clock,
   input wire logic [4:0] i_cmd,
   output logic o_brake_release,
   output logic o_home,
   output logic o_jog_plus,
   output logic o_jog_minus,
   output logic o_pos_write
);
   // lines follow the plc program one cycle later
   always_ff @(posedge i_clock) begin
      {o_brake_release, o_home, o_jog_plus, o_jog_minus, o_pos_write} <= i_cmd;
   end
endmodule
`default_nettype wire

// ### sim/pios_top_tb.sv
// self-checking bench of the parallel io pattern select block
`timescale 1ns/10ps
`default_nettype none
module pios_top_tb;
   logic i_clock = 1'h0, i_sys_rst = 1'h1;
   logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
   logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0;
   logic i_rready = 1'h0, i_servo_ready = 1'h0;
   logic [31:0] i_wdata = 32'h0, seed = 32'h00014E64;
   logic [3:0] i_wstrb = 4'hF;
   logic [6:0] i_at_point = 7'h00;
   logic [4:0] cmd = 5'h00;
   wire logic i_brake_release, i_home, i_jog_plus, i_jog_minus, i_pos_write;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_brake_release, o_home;
   logic o_jog_plus, o_jog_minus, o_pos_write, o_parameter_zone_output, o_ready;
   logic o_table_zone_output, o_direct_select, o_complete_as_detect, o_push_enable;
   logic [1:0] o_bresp, o_rresp;
   logic [31:0] o_rdata;
   logic [9:0] o_point_count;
   logic [6:0] o_point_detect;
   int errors = 0, checked = 0, mp = 0;
   logic [31:0] model_q[$];
   int cnt[8] = '{64, 64, 256, 512, 7, 3, 0, 0};
   int pv[8] = '{32'h63, 32'h64, 32'hC8, 32'hC9, 32'h12B, 32'h12C, 32'h190, 32'h191};

   pios_top uut (.*);
   pios_plc plc (.i_clock(i_clock), .i_cmd(cmd), .o_brake_release(i_brake_release),
      .o_home(i_home), .o_jog_plus(i_jog_plus), .o_jog_minus(i_jog_minus),
      .o_pos_write(i_pos_write));

   initial forever #10 i_clock = ~i_clock;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge i_clock);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'h1;
      i_wvalid <= 1'h1;
      i_bready <= 1'h1;
      do begin
         @(posedge i_clock);
         if (i_awvalid && o_awready) i_awvalid <= 1'h0;
         if (i_wvalid && o_wready) i_wvalid <= 1'h0;
      end while (!(i_bready && o_bvalid));
      r = o_bresp;
      i_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_clock);
      i_araddr <= a;
      i_arvalid <= 1'h1;
      i_rready <= 1'h1;
      do begin
         @(posedge i_clock);
         if (i_arvalid && o_arready) i_arvalid <= 1'h0;
      end while (!(i_rready && o_rvalid));
      d = o_rdata;
      r = o_rresp;
      i_rready <= 1'h0;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (5000) @(posedge i_clock);
      errors++;
      complete_run();
   end
   initial begin
      int p, pos, ctl;
      logic [31:0] d, w;
      logic [1:0] r;
      logic pz, tz;
      repeat (5) @(posedge i_clock);
      i_sys_rst <= 1'h0;
      @(posedge i_clock);
      chk({o_awready, o_wready, o_arready, o_point_count}, {3'h7, 10'h040});
      $display("test reset done");
      wr(pios_pkg::OFS_ZONE_LO, 32'h64, r);
      wr(pios_pkg::OFS_ZONE_HI, 32'hC8, r);
      wr(pios_pkg::OFS_TBL_LO, 32'h12C, r);
      wr(pios_pkg::OFS_TBL_HI, 32'h190, r);
      for (p = 0; p < 8; p++) begin
         wr(pios_pkg::OFS_PATTERN, p, r);
         chk(r, p > 5 ? pios_pkg::RESP_SLVERR : pios_pkg::RESP_OKAY);
         if (p < 6) mp = p;
         rd(pios_pkg::OFS_PATTERN, d, r);
         chk(d, mp);
         repeat (6) begin
            pos = pv[xs() % 8];
            ctl = xs() % 8;
            wr(pios_pkg::OFS_POS, pos, r);
            wr(pios_pkg::OFS_CTRL, ctl, r);
            w = xs();
            cmd <= w[4:0];
            i_servo_ready <= w[5];
            i_at_point <= w[12:6];
            repeat (3) @(posedge i_clock);
            pz = ctl[0] && pos >= 32'h64 && pos <= 32'hC8 && (mp == 0 || mp > 3);
            tz = ctl[1] && pos >= 32'h12C && pos <= 32'h190 && mp != 3;
            chk({o_brake_release, o_home, o_jog_plus, o_jog_minus, o_pos_write},
               w[4:0] & {mp != 1, mp != 5, {3{mp == 1}}});
            chk({o_ready, o_point_detect},
               {w[5] && mp < 2, mp == 5 ? {4'h0, w[8:6]} : 7'h00});
            chk({o_point_count, o_direct_select, o_complete_as_detect, o_push_enable},
               {cnt[mp][9:0], mp > 3, mp == 5, ctl[2] && mp != 5});
            chk({o_parameter_zone_output, o_table_zone_output}, {pz, tz});
            model_q.push_back({20'h0, cnt[mp][9:0], tz, pz});
            rd(pios_pkg::OFS_STATUS, d, r);
            chk(d, model_q.pop_front());
         end
         $display("test pattern %0d done", p);
      end
      rd(pios_pkg::OFS_PARAM_NO, d, r);
      chk({r, d}, {pios_pkg::RESP_OKAY, 32'h19});
      wr(pios_pkg::OFS_PARAM_NO, 32'h0, r);
      chk(r, pios_pkg::RESP_SLVERR);
      rd(8'h24, d, r);
      chk({r, d}, {pios_pkg::RESP_SLVERR, 32'h0});
      i_wstrb <= 4'h1;
      wr(pios_pkg::OFS_PATTERN, 32'hFFFF_FF03, r);
      chk(r, pios_pkg::RESP_OKAY);
      i_wstrb <= 4'h2;
      wr(pios_pkg::OFS_PATTERN, 32'h0000_0100, r);
      chk(r, pios_pkg::RESP_SLVERR);
      i_wstrb <= 4'hF;
      rd(pios_pkg::OFS_PATTERN, d, r);
      chk(d, 32'h3);
      $display("test registers done");
      i_sys_rst <= 1'h1;
      repeat (2) @(posedge i_clock);
      i_sys_rst <= 1'h0;
      rd(pios_pkg::OFS_PATTERN, d, r);
      chk({r, d}, {pios_pkg::RESP_OKAY, 32'h0});
      $display("test reset again done");
      complete_run();
   end
endmodule
`default_nettype wire
